// *** src/sac_top.sv ***
// conversion control: registers, triggers, fifo, interlock, abort
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic HW_TRIG_I,
  input wire logic ALT_CLK_I,
  input wire logic ASYNC_CLK_I,
  input wire logic STOP_I,
  input wire logic CMP_I,
  output logic SAMPLE_O,
  output logic [11:0] DAC_O,
  output logic [4:0] CHANNEL_O,
  output logic ACTIVE_O,
  output logic ASYNC_CLK_EN_O,
  output logic IRQ_O,
  output logic [11:0] PIN_ANALOG_O,
  input wire logic [11:0] PORT_IN_I,
  output logic [11:0] PORT_READ_O
);
  typedef enum logic {ST_IDLE, ST_CONV} sac_state_t;
  sac_state_t state;

  logic [4:0] ch;
  logic done_ie;
  logic cont;
  logic done_flag;
  logic hw_en;
  logic cmp_en;
  logic cmp_gt;
  logic [1:0] div;
  logic lsmp;
  logic [1:0] mode;
  logic [1:0] src;
  logic [3:0] depth;
  logic [3:0] cvh;
  logic [7:0] cvl;
  logic [11:0] apc;
  logic [11:0] res_q [0:7];
  logic [4:0] chan_q [0:7];
  logic [2:0] cidx;
  logic [2:0] ridx;
  logic [3:0] wcnt;
  logic hi_read;
  logic trig_prev;
  logic [7:0] rdata;
  logic [11:0] port_rd;

  logic tick;
  logic eng_busy;
  logic eng_done;
  logic [11:0] eng_res;

  // bus decode
  wire wr_sc1 = WR_I && (ADDR_I == OFS_SC1);
  wire wr_sc2 = WR_I && (ADDR_I == OFS_SC2);
  wire wr_sc3 = WR_I && (ADDR_I == OFS_SC3);
  wire wr_sc4 = WR_I && (ADDR_I == OFS_SC4);
  wire wr_cvh = WR_I && (ADDR_I == OFS_CVH);
  wire wr_cvl = WR_I && (ADDR_I == OFS_CVL);
  wire wr_apl = WR_I && (ADDR_I == OFS_APL);
  wire wr_aph = WR_I && (ADDR_I == OFS_APH);
  wire rd_rh = RD_I && (ADDR_I == OFS_RH);
  wire rd_rl = RD_I && (ADDR_I == OFS_RL);
  wire cfg_wr = wr_sc2 | wr_sc3 | wr_sc4 | wr_cvh | wr_cvl;

  // configuration
  wire fifo_on = depth != 4'h0;
  wire mode8 = mode == MODE_8;
  wire [4:0] wch = WDATA_I[4:0];
  wire wch_ok = wch != CH_OFF;
  wire [3:0] wdep = WDATA_I[3:0];

  // fifo bookkeeping; a full fifo restarts its fill on the next write
  wire [2:0] wr_slot = (wcnt == depth) ? 3'h0 : wcnt[2:0];
  wire [3:0] wcnt_after = {1'b0, wr_slot} + 4'h1;
  wire [3:0] cidx_inc = {1'b0, cidx} + 4'h1;
  wire [3:0] ridx_inc = {1'b0, ridx} + 4'h1;
  wire last = cidx_inc == depth;
  wire [2:0] st_idx = fifo_on ? cidx : 3'h0;
  wire [11:0] cur_res = res_q[fifo_on ? ridx : 3'h0];
  wire [4:0] conv_ch = fifo_on ? chan_q[cidx] : ch;

  // aborts; stop only spares a conversion clocked from the async source
  wire stop_abort = STOP_I && (src != SRC_ASYNC);
  wire abort_any = wr_sc1 | cfg_wr | stop_abort;

  // result formatting
  wire [12:0] rnd10 = {1'b0, eng_res} + ROUND10;
  wire [12:0] rnd8 = {1'b0, eng_res} + ROUND8;
  wire [11:0] fmt10 = rnd10[12] ? MAX10 : {2'h0, rnd10[11:2]};
  wire [11:0] fmt8 = rnd8[12] ? MAX8 : {4'h0, rnd8[11:4]};
  wire [11:0] fmt = (mode == MODE_12) ? eng_res : (mode == MODE_10) ? fmt10 : fmt8;

  // compare, applied in every mode and trigger setting while the fifo is off
  wire [11:0] cmp_val = {cvh, cvl};
  wire cmp_ge = fmt >= cmp_val;
  wire cmp_ok = ~cmp_en | (cmp_gt ? cmp_ge : ~cmp_ge);

  // completion handling
  wire blocked = hi_read;
  wire xfer = eng_done & ~blocked & (fifo_on | cmp_ok);
  wire done_set = xfer & (~fifo_on | last);
  wire restart = eng_done & ~abort_any &
                 (blocked ? (fifo_on | cont | cmp_ok) :
                  fifo_on ? (~last | cont) : cont);

  // starts
  wire trig_rise = HW_TRIG_I & ~trig_prev;
  wire sw_start = wr_sc1 & wch_ok & ~hw_en &
                  (~fifo_on | (wcnt_after == depth));
  wire hw_start = hw_en & trig_rise & (state == ST_IDLE) & ~abort_any &
                  (fifo_on ? (wcnt == depth) : (ch != CH_OFF));
  wire eng_start = sw_start | hw_start | restart;

  // read selection
  wire [7:0] sc1_rd = {done_flag, done_ie, cont, conv_ch};
  wire [7:0] sc2_rd = {2'h0, hw_en, cmp_en, cmp_gt, 3'h0};
  wire [7:0] sc3_rd = {1'b0, div, lsmp, mode, src};
  wire [7:0] sc4_rd = {4'h0, depth};
  wire [7:0] rh_rd = mode8 ? 8'h00 : {4'h0, cur_res[11:8]};
  wire [7:0] rd_mux = (ADDR_I == OFS_SC1) ? sc1_rd :
                      (ADDR_I == OFS_SC2) ? sc2_rd :
                      (ADDR_I == OFS_SC3) ? sc3_rd :
                      (ADDR_I == OFS_SC4) ? sc4_rd :
                      (ADDR_I == OFS_RH) ? rh_rd :
                      (ADDR_I == OFS_RL) ? cur_res[7:0] :
                      (ADDR_I == OFS_CVH) ? {4'h0, cvh} :
                      (ADDR_I == OFS_CVL) ? cvl :
                      (ADDR_I == OFS_APL) ? apc[7:0] :
                      (ADDR_I == OFS_APH) ? {4'h0, apc[11:8]} : 8'h00;

  // set wins over the clear in the same cycle
  wire next_done = done_set | (done_flag & ~(wr_sc1 | rd_rl));
  wire next_hi_read = (rd_rh & ~mode8) | (hi_read & ~rd_rl);

  sac_clkdiv u_clkdiv (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .src_i(src),
    .div_i(div),
    .alt_clk_i(ALT_CLK_I),
    .async_clk_i(ASYNC_CLK_I),
    .tick_o(tick)
  );

  sac_approx u_approx (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .tick_i(tick),
    .start_i(eng_start),
    .abort_i(abort_any),
    .long_i(lsmp),
    .cmp_i(CMP_I),
    .sample_o(SAMPLE_O),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .dac_o(DAC_O),
    .result_o(eng_res)
  );

  assign RDATA_O = rdata;
  assign CHANNEL_O = conv_ch;
  assign ACTIVE_O = state == ST_CONV;
  assign ASYNC_CLK_EN_O = (state == ST_CONV) && (src == SRC_ASYNC);
  assign IRQ_O = done_flag & done_ie;
  assign PIN_ANALOG_O = apc;
  assign PORT_READ_O = port_rd;

  // control registers
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ch <= CH_OFF;
      done_ie <= 1'b0;
      cont <= 1'b0;
      hw_en <= 1'b0;
      cmp_en <= 1'b0;
      cmp_gt <= 1'b0;
      div <= 2'h0;
      lsmp <= 1'b0;
      mode <= MODE_8;
      src <= SRC_BUS;
      depth <= 4'h0;
      cvh <= 4'h0;
      cvl <= 8'h00;
      apc <= 12'h000;
    end else if (CE_I) begin
      if (wr_sc1) begin
        done_ie <= WDATA_I[SC1_IE];
        cont <= WDATA_I[SC1_CONT];
        ch <= wch;
      end
      if (wr_sc2) begin
        hw_en <= WDATA_I[SC2_HWT];
        cmp_en <= WDATA_I[SC2_CMPEN];
        cmp_gt <= WDATA_I[SC2_CMPGT];
      end
      if (wr_sc3) begin
        div <= WDATA_I[SC3_DIV +: 2];
        lsmp <= WDATA_I[SC3_LSMP];
        mode <= WDATA_I[SC3_MODE +: 2];
        src <= WDATA_I[1:0];
      end
      if (wr_sc4) begin
        depth <= (wdep > FIFO_MAX) ? FIFO_MAX : wdep;
      end
      if (wr_cvh) begin
        cvh <= WDATA_I[3:0];
      end
      if (wr_cvl) begin
        cvl <= WDATA_I;
      end
      if (wr_apl) begin
        apc[7:0] <= WDATA_I;
      end
      if (wr_aph) begin
        apc[11:8] <= WDATA_I[3:0];
      end
    end
  end

  // sequencing, flags and bus answer
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      done_flag <= 1'b0;
      hi_read <= 1'b0;
      trig_prev <= 1'b0;
      rdata <= 8'h00;
      port_rd <= 12'h000;
    end else if (CE_I) begin
      done_flag <= next_done;
      hi_read <= next_hi_read;
      trig_prev <= HW_TRIG_I;
      rdata <= RD_I ? rd_mux : 8'h00;
      port_rd <= PORT_IN_I & ~apc;
      if (eng_start) begin
        state <= ST_CONV;
      end else if (abort_any || eng_done) begin
        state <= ST_IDLE;
      end
    end
  end

  // result and channel storage; reset alone clears results
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < 8; i++) begin
        res_q[i] <= 12'h000;
        chan_q[i] <= CH_OFF;
      end
      cidx <= 3'h0;
      ridx <= 3'h0;
      wcnt <= 4'h0;
    end else if (CE_I) begin
      if (xfer) begin
        res_q[st_idx] <= fmt;
        if (fifo_on) begin
          cidx <= last ? 3'h0 : cidx_inc[2:0];
        end
      end
      if (rd_rl && fifo_on) begin
        ridx <= (ridx_inc == depth) ? 3'h0 : ridx_inc[2:0];
      end
      if (wr_sc1 && fifo_on) begin
        cidx <= 3'h0;
        if (!wch_ok) begin
          wcnt <= 4'h0;
        end else begin
          chan_q[wr_slot] <= wch;
          wcnt <= wcnt_after;
          if (wr_slot == 3'h0) begin
            ridx <= 3'h0;
          end
        end
      end else if (cfg_wr) begin
        cidx <= 3'h0;
        wcnt <= 4'h0;
      end
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  chan_valid_a: assert property (
    (CE_I && eng_start && !fifo_on) |=> (ch != CH_OFF))
    else $error("conversion started with channel select all ones");

  done_set_a: assert property (
    (CE_I && done_set) |=> (done_flag && (IRQ_O == done_ie)))
    else $error("done flag or interrupt missing after transfer");

  block_hold_a: assert property (
    (CE_I && eng_done && hi_read && !fifo_on && !rd_rl && !wr_sc1)
    |=> ($stable(cur_res) && !$rose(done_flag)))
    else $error("result transferred while interlock active");

  // an edge seen mid-approximation must not send the engine back to sampling
  hw_busy_a: assert property (
    (CE_I && !cont && trig_rise && eng_busy && !SAMPLE_O && !wr_sc1) |=> !SAMPLE_O)
    else $error("trigger edge acted on during conversion");

  cont_edge_a: assert property (
    (CE_I && cont && hw_en && trig_rise && eng_busy && !SAMPLE_O && !abort_any)
    |=> !SAMPLE_O)
    else $error("later trigger edge acted on in continuous mode");

  stop_abort_a: assert property (
    (CE_I && stop_abort && !wr_sc1) |=> (state == ST_IDLE))
    else $error("stop without async clock did not abort");

  cfg_abort_a: assert property (
    (CE_I && cfg_wr && !wr_sc1) |=> (state == ST_IDLE && wcnt == 4'h0))
    else $error("configuration write did not abort");

  round8_a: assert property (
    (CE_I && xfer && !fifo_on && mode == MODE_8) |=> (cur_res[11:8] == 4'h0))
    else $error("eight bit result wider than eight bits");

  cmp_keep_a: assert property (
    (CE_I && eng_done && !fifo_on && !cmp_ok) |=> ($stable(cur_res) && !$rose(done_flag)))
    else $error("result updated with compare not met");

  blk_restart_a: assert property (
    (CE_I && eng_done && hi_read && !abort_any && (cont || cmp_ok || fifo_on))
    |=> (state == ST_CONV))
    else $error("blocked transfer did not start another conversion");

  single_stop_a: assert property (
    (CE_I && eng_done && !fifo_on && !cont && !cmp_ok && !abort_any)
    |=> (state == ST_IDLE))
    else $error("single compare-false conversion did not stop");

  cont_next_a: assert property (
    (CE_I && eng_done && cont && !abort_any) |=> (state == ST_CONV && SAMPLE_O))
    else $error("continuous mode did not start the next conversion");

  pin_gate_a: assert property (
    (CE_I && $stable(apc)) |=> ((PORT_READ_O & $past(apc)) == 12'h000))
    else $error("analog pin read back nonzero");
endmodule // sac_top

// *** src/sac_pkg.sv ***
// package: constants of the sar converter control block
package sac_pkg;
  localparam logic [3:0] OFS_SC1 = 4'h0;
  localparam logic [3:0] OFS_SC2 = 4'h1;
  localparam logic [3:0] OFS_SC3 = 4'h2;
  localparam logic [3:0] OFS_SC4 = 4'h3;
  localparam logic [3:0] OFS_RH = 4'h4;
  localparam logic [3:0] OFS_RL = 4'h5;
  localparam logic [3:0] OFS_CVH = 4'h6;
  localparam logic [3:0] OFS_CVL = 4'h7;
  localparam logic [3:0] OFS_APL = 4'h8;
  localparam logic [3:0] OFS_APH = 4'h9;
  localparam int SC1_IE = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_HWT = 5;
  localparam int SC2_CMPEN = 4;
  localparam int SC2_CMPGT = 3;
  localparam int SC3_DIV = 5;
  localparam int SC3_LSMP = 4;
  localparam int SC3_MODE = 2;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS2 = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  // 3.5 and 23.5 converter clocks, rounded up to whole clocks
  localparam logic [5:0] SAMPLE_SHORT = 6'h04;
  localparam logic [5:0] SAMPLE_LONG = 6'h18;
  localparam logic [11:0] MSB_TRIAL = 12'h800;
  localparam logic [12:0] ROUND10 = 13'h0002;
  localparam logic [12:0] ROUND8 = 13'h0008;
  localparam logic [11:0] MAX10 = 12'h3FF;
  localparam logic [11:0] MAX8 = 12'h0FF;
  localparam logic [3:0] FIFO_MAX = 4'h8;
endpackage

// *** src/sac_clkdiv.sv ***
// converter clock source select and divider, as a tick enable
`timescale 1ns/1ps
module sac_clkdiv
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] src_i,
  input wire logic [1:0] div_i,
  input wire logic alt_clk_i,
  input wire logic async_clk_i,
  output logic tick_o
);
  logic half;
  logic alt_prev;
  logic asy_prev;
  logic [2:0] cnt;
  wire [3:0] ratio = 4'h1 << div_i;
  wire [2:0] ratio_m1 = 3'(ratio - 4'h1);
  wire alt_rise = alt_clk_i & ~alt_prev;
  wire asy_rise = async_clk_i & ~asy_prev;
  wire src_tick = (src_i == SRC_BUS) ? 1'b1 :
                  (src_i == SRC_BUS2) ? half :
                  (src_i == SRC_ALT) ? alt_rise : asy_rise;
  assign tick_o = src_tick & (cnt == ratio_m1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half <= 1'b0;
      alt_prev <= 1'b0;
      asy_prev <= 1'b0;
      cnt <= 3'h0;
    end else if (ce_i) begin
      half <= ~half;
      alt_prev <= alt_clk_i;
      asy_prev <= async_clk_i;
      if (src_tick) begin
        cnt <= (cnt == ratio_m1) ? 3'h0 : 3'(cnt + 3'h1);
      end
    end
  end
endmodule // sac_clkdiv

// *** src/sac_approx.sv ***
// sample phase and successive approximation sequencer
`timescale 1ns/1ps
module sac_approx
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic long_i,
  input wire logic cmp_i,
  output logic sample_o,
  output logic busy_o,
  output logic done_o,
  output logic [11:0] dac_o,
  output logic [11:0] result_o
);
  typedef enum logic [1:0] {AP_IDLE, AP_SAMPLE, AP_APPROX} sac_ap_t;
  sac_ap_t st;
  logic [5:0] cnt;
  logic [11:0] mask;
  // comparator high means input at or above the trial level
  wire [11:0] kept = cmp_i ? dac_o : (dac_o & ~mask);
  assign busy_o = st != AP_IDLE;
  assign sample_o = st == AP_SAMPLE;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= AP_IDLE;
      cnt <= 6'h00;
      mask <= 12'h000;
      dac_o <= 12'h000;
      result_o <= 12'h000;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        st <= AP_SAMPLE;
        cnt <= long_i ? SAMPLE_LONG : SAMPLE_SHORT;
        dac_o <= 12'h000;
      end else if (abort_i) begin
        st <= AP_IDLE;
      end else if (tick_i) begin
        unique case (st)
          AP_IDLE: begin
            mask <= 12'h000;
          end
          AP_SAMPLE: begin
            if (cnt == 6'h01) begin
              st <= AP_APPROX;
              mask <= MSB_TRIAL;
              dac_o <= MSB_TRIAL;
            end else begin
              cnt <= cnt - 6'h01;
            end
          end
          AP_APPROX: begin
            dac_o <= kept | (mask >> 1);
            mask <= mask >> 1;
            if (mask[0]) begin
              result_o <= kept;
              done_o <= 1'b1;
              st <= AP_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // sac_approx

// *** verification/sac_core_model.sv ***
// analog core stand-in: comparator against a settable input level
`timescale 1ns/1ps
module sac_core_model (
  input wire logic [11:0] dac_i,
  input wire logic [11:0] level_i,
  output logic cmp_o
);
  // ideal comparator, no offset or noise, so results are exact
  assign cmp_o = (level_i >= dac_i);
endmodule // sac_core_model

// *** verification/sac_top_tb_top.sv ***
// self-checking testbench of the conversion control block
`timescale 1ns/1ps
module sac_top_tb_top
  import sac_pkg::*;
;
  logic CLOCK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CE_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic HW_TRIG_I = 1'b0;
  logic ALT_CLK_I = 1'b0;
  logic ASYNC_CLK_I = 1'b0;
  logic STOP_I = 1'b0;
  logic [11:0] PORT_IN_I = 12'h000;
  logic CMP_I;
  logic [7:0] RDATA_O;
  logic SAMPLE_O;
  logic [11:0] DAC_O;
  logic [4:0] CHANNEL_O;
  logic ACTIVE_O;
  logic ASYNC_CLK_EN_O;
  logic IRQ_O;
  logic [11:0] PIN_ANALOG_O;
  logic [11:0] PORT_READ_O;
  logic [11:0] level = 12'h000;
  logic [2:0] ph = 3'h0;
  logic [11:0] e;
  logic [7:0] cfg [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h48, 8'h70};
  int fac [6] = '{1, 2, 4, 8, 4, 8};
  int mismatches = 0;
  int compares = 0;
  int c;
  int t;

  always #50 CLOCK_I = ~CLOCK_I;
  // alternate source ticks every 4 cycles, async source every 8
  always @(posedge CLOCK_I) begin
    ph <= ph + 3'h1;
    ALT_CLK_I <= ph[1];
    ASYNC_CLK_I <= ph[2];
  end

  sac_top DUT (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .HW_TRIG_I(HW_TRIG_I), .ALT_CLK_I(ALT_CLK_I), .ASYNC_CLK_I(ASYNC_CLK_I),
    .STOP_I(STOP_I), .CMP_I(CMP_I), .SAMPLE_O(SAMPLE_O), .DAC_O(DAC_O),
    .CHANNEL_O(CHANNEL_O), .ACTIVE_O(ACTIVE_O), .ASYNC_CLK_EN_O(ASYNC_CLK_EN_O),
    .IRQ_O(IRQ_O), .PIN_ANALOG_O(PIN_ANALOG_O), .PORT_IN_I(PORT_IN_I),
    .PORT_READ_O(PORT_READ_O)
  );

  sac_core_model core (.dac_i(DAC_O), .level_i(level), .cmp_o(CMP_I));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // one idle cycle after each strobe keeps a strobe from being set twice per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
    @(posedge CLOCK_I);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] x);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    @(posedge CLOCK_I);
    chk({4'h0, RDATA_O}, {4'h0, x});
  endtask

  task automatic waiti(input int n);
    c = 0;
    while (IRQ_O !== 1'b1 && c < n) begin
      @(posedge CLOCK_I);
      c++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK_I);
  endtask

  function automatic logic [11:0] fmt(input logic [11:0] v, input logic [1:0] m);
    logic [12:0] s;
    s = {1'b0, v} + ((m == MODE_10) ? ROUND10 : ROUND8);
    if (m == MODE_12) return v;
    if (m == MODE_10) return s[12] ? MAX10 : {2'h0, s[11:2]};
    return s[12] ? MAX8 : {4'h0, s[11:4]};
  endfunction

  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    tick(10);
    RST_N_I <= 1'b1;
    tick(1);
    rdc(OFS_RH, 8'h00);
    rdc(OFS_RL, 8'h00);
    rdc(OFS_SC1, 8'h1F);
    rdc(4'hF, 8'h00);
    wr(OFS_SC1, 8'h1F);
    tick(3);
    chk({11'h0, ACTIVE_O}, 12'h000);
    chk({7'h0, CHANNEL_O}, 12'h01F);
    wr(OFS_APL, 8'hF0);
    wr(OFS_APH, 8'h05);
    PORT_IN_I <= 12'hFFF;
    tick(2);
    chk(PIN_ANALOG_O, 12'h5F0);
    chk(PORT_READ_O, 12'hA0F);
    // every source, sample length and resolution, with dividers 1, 4 and 8
    for (int i = 0; i < 6; i++) begin
      level <= (i == 5) ? 12'hFFE : 12'hA5E;
      wr(OFS_SC3, cfg[i]);
      wr(OFS_SC1, 8'h45);
      waiti(400);
      t = cfg[i][SC3_LSMP] ? 36 : 16;
      chk({11'h0, c >= (t - 1) * fac[i] && c <= (t + 2) * fac[i] + 4}, 12'h1);
      chk({11'h0, IRQ_O}, 12'h001);
      e = fmt(level, cfg[i][3:2]);
      rdc(OFS_RH, {4'h0, e[11:8]});
      rdc(OFS_RL, e[7:0]);
    end
    wr(OFS_SC3, 8'h07);
    level <= 12'h3C4;
    wr(OFS_SC1, 8'h45);
    tick(10);
    chk({11'h0, ASYNC_CLK_EN_O}, 12'h001);
    STOP_I <= 1'b1;
    waiti(400);
    chk({11'h0, IRQ_O}, 12'h001);
    STOP_I <= 1'b0;
    rdc(OFS_RH, 8'h03);
    rdc(OFS_RL, 8'hC4);
    chk({10'h0, ASYNC_CLK_EN_O, ACTIVE_O}, 12'h000);
    // stop with a clocked source kills the conversion, results stay
    wr(OFS_SC3, 8'h04);
    level <= 12'h777;
    wr(OFS_SC1, 8'h45);
    tick(5);
    STOP_I <= 1'b1;
    tick(3);
    chk({11'h0, ACTIVE_O}, 12'h000);
    STOP_I <= 1'b0;
    tick(30);
    chk({11'h0, IRQ_O}, 12'h000);
    rdc(OFS_RL, 8'hC4);
    level <= 12'h111;
    wr(OFS_SC1, 8'h45);
    waiti(60);
    rdc(OFS_RH, 8'h01);
    level <= 12'h222;
    wr(OFS_SC1, 8'h45);
    waiti(60);
    chk({11'h0, IRQ_O}, 12'h000);
    rdc(OFS_RL, 8'h11);
    waiti(40);
    chk({11'h0, IRQ_O}, 12'h001);
    rdc(OFS_RH, 8'h02);
    rdc(OFS_RL, 8'h22);
    wr(OFS_SC2, 8'h20);
    level <= 12'h456;
    wr(OFS_SC1, 8'h45);
    tick(3);
    chk({11'h0, ACTIVE_O}, 12'h000);
    HW_TRIG_I <= 1'b1;
    tick(4);
    chk({11'h0, ACTIVE_O}, 12'h001);
    HW_TRIG_I <= 1'b0;
    tick(4);
    HW_TRIG_I <= 1'b1;
    waiti(40);
    // a restart on the second edge would push completion well past 14 cycles
    chk({11'h0, c <= 14}, 12'h001);
    HW_TRIG_I <= 1'b0;
    rdc(OFS_RL, 8'h56);
    wr(OFS_SC1, 8'h65);
    tick(3);
    chk({11'h0, ACTIVE_O}, 12'h000);
    HW_TRIG_I <= 1'b1;
    waiti(40);
    HW_TRIG_I <= 1'b0;
    chk({11'h0, IRQ_O}, 12'h001);
    rdc(OFS_RL, 8'h56);
    HW_TRIG_I <= 1'b1;
    waiti(40);
    chk({11'h0, IRQ_O}, 12'h001);
    HW_TRIG_I <= 1'b0;
    rdc(OFS_RH, 8'h04);
    rdc(OFS_RL, 8'h56);
    wr(OFS_SC2, 8'h18);
    tick(3);
    chk({11'h0, ACTIVE_O}, 12'h000);
    wr(OFS_CVH, 8'h08);
    wr(OFS_CVL, 8'h00);
    level <= 12'h100;
    wr(OFS_SC1, 8'h45);
    waiti(60);
    chk({11'h0, IRQ_O}, 12'h000);
    chk({11'h0, ACTIVE_O}, 12'h000);
    rdc(OFS_RL, 8'h56);
    level <= 12'h900;
    wr(OFS_SC1, 8'h45);
    waiti(60);
    chk({11'h0, IRQ_O}, 12'h001);
    rdc(OFS_RH, 8'h09);
    rdc(OFS_RL, 8'h00);
    // low clock enable freezes a conversion just after its sample phase
    level <= 12'h9AB;
    wr(OFS_SC1, 8'h45);
    tick(3);
    CE_I <= 1'b0;
    tick(40);
    chk(DAC_O, 12'h800);
    chk({10'h0, ACTIVE_O, IRQ_O}, 12'h002);
    CE_I <= 1'b1;
    waiti(40);
    chk({11'h0, IRQ_O}, 12'h001);
    rdc(OFS_RH, 8'h09);
    rdc(OFS_RL, 8'hAB);
    // reset in mid-conversion returns results to zero
    wr(OFS_SC1, 8'h45);
    tick(5);
    RST_N_I <= 1'b0;
    tick(2);
    RST_N_I <= 1'b1;
    tick(1);
    chk({11'h0, ACTIVE_O}, 12'h000);
    chk(PIN_ANALOG_O, 12'h000);
    rdc(OFS_RH, 8'h00);
    rdc(OFS_RL, 8'h00);
    report_and_stop();
  end
endmodule // sac_top_tb_top
